// ===== common/amos_map.vh
// register offsets, field positions, reset values and divider counts
`ifndef AMOS_MAP_VH
`define AMOS_MAP_VH

// register offsets
`define AMOS_CONTROL_OFS 8'h07
`define AMOS_A0_SEC_OFS 8'h0A
`define AMOS_A0_MIN_OFS 8'h0B
`define AMOS_A0_HOUR_OFS 8'h0C
`define AMOS_A0_WKDAY_OFS 8'h0D
`define AMOS_A0_DATE_OFS 8'h0E
`define AMOS_A0_MONTH_OFS 8'h0F
`define AMOS_A1_SEC_OFS 8'h11
`define AMOS_A1_MIN_OFS 8'h12
`define AMOS_A1_HOUR_OFS 8'h13
`define AMOS_A1_WKDAY_OFS 8'h14
`define AMOS_A1_DATE_OFS 8'h15
`define AMOS_A1_MONTH_OFS 8'h16

// alarm weekday and config fields
`define AMOS_WK_POL_BIT 7
`define AMOS_WK_SEL_HI 6
`define AMOS_WK_SEL_LO 4
`define AMOS_WK_FLAG_BIT 3
`define AMOS_HOUR_FMT_BIT 6

// control fields
`define AMOS_CTL_LEVEL_BIT 7
`define AMOS_CTL_SQW_EN_BIT 6
`define AMOS_CTL_A1_EN_BIT 5
`define AMOS_CTL_A0_EN_BIT 4

// match select codes
`define AMOS_SEL_SEC 3'h0
`define AMOS_SEL_MIN 3'h1
`define AMOS_SEL_HOUR 3'h2
`define AMOS_SEL_WKDAY 3'h3
`define AMOS_SEL_DATE 3'h4
`define AMOS_SEL_ALL 3'h7

// reset values
`define AMOS_CONTROL_RST 8'h80
`define AMOS_WKDAY_RST 3'h1
`define AMOS_DATE_RST 6'h01
`define AMOS_MONTH_RST 5'h01

// half periods of the square wave minus one, in oscillator rising edges
`define AMOS_HALF_DIV32768 14'h3FFF
`define AMOS_HALF_DIV8 14'h0003
`define AMOS_HALF_DIV4 14'h0001

`endif

// ===== hw/amos_match_eval.v
// comparison of one alarm's stored values against the current time
`timescale 1ns/1ps
module amos_match_eval (
    input wire [2:0] match_sel,
    input wire [6:0] alarm_sec,
    input wire [6:0] alarm_min,
    input wire [5:0] alarm_hour,
    input wire [2:0] alarm_wkday,
    input wire [5:0] alarm_date,
    input wire [4:0] alarm_month,
    input wire [6:0] now_sec,
    input wire [6:0] now_min,
    input wire [5:0] now_hour,
    input wire [2:0] now_wkday,
    input wire [5:0] now_date,
    input wire [4:0] now_month,
    output reg match
);
`include "amos_map.vh"

    wire sec_eq;
    wire min_eq;
    wire hour_eq;
    wire wkday_eq;
    wire date_eq;
    wire month_eq;

    assign sec_eq = (alarm_sec == now_sec);
    assign min_eq = (alarm_min == now_min);
    // bits 5..0 carry meridiem and tens in 12-hour, two-bit tens in 24-hour
    assign hour_eq = (alarm_hour == now_hour);
    assign wkday_eq = (alarm_wkday == now_wkday);
    assign date_eq = (alarm_date == now_date);
    assign month_eq = (alarm_month == now_month);

    always @* begin
        case (match_sel)
            `AMOS_SEL_SEC: match = sec_eq;
            `AMOS_SEL_MIN: match = min_eq;
            `AMOS_SEL_HOUR: match = hour_eq;
            `AMOS_SEL_WKDAY: match = wkday_eq;
            `AMOS_SEL_DATE: match = date_eq;
            `AMOS_SEL_ALL: match = sec_eq & min_eq & hour_eq & wkday_eq &
                date_eq & month_eq;
            // reserved codes never match
            default: match = 1'b0;
        endcase
    end

endmodule // amos_match_eval

// ===== hw/amos_top.v
// dual alarm match, registers and multi-function pin output select
`timescale 1ns/1ps
module amos_top (
    input wire clk,
    input wire resetn,
    input wire ce,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_we,
    output reg [7:0] reg_rdata,
    input wire [6:0] now_sec,
    input wire [6:0] now_min,
    input wire [5:0] now_hour,
    input wire now_format_12h,
    input wire [2:0] now_wkday,
    input wire [5:0] now_date,
    input wire [4:0] now_month,
    input wire sec_tick,
    input wire osc_in,
    output reg multi_function_pin_out,
    output reg multi_function_pin_oe_n,
    output reg first_alarm_match_flag,
    output reg second_alarm_match_flag
);
`include "amos_map.vh"

    ////////////////////////////////////////////////////////////////////////
    // storage

    reg [6:0] sec_reg [0:1];
    reg [6:0] min_reg [0:1];
    reg [5:0] hour_reg [0:1];
    reg [2:0] day_of_week_value_reg [0:1];
    reg [2:0] alarm_match_select_reg [0:1];
    reg alarm_output_polarity_reg [0:1];
    reg [5:0] date_reg [0:1];
    reg [4:0] month_reg [0:1];
    reg [7:0] control_reg;
    reg [1:0] flag_next;
    reg [7:0] rdata_next;
    integer i;
    integer k;

    wire square_wave_enable;
    wire first_alarm_enable;
    wire second_alarm_enable;
    wire [1:0] square_wave_rate_select;
    wire [1:0] alarm_en;
    wire [1:0] match;
    wire [1:0] flag_now;

    assign square_wave_enable = control_reg[`AMOS_CTL_SQW_EN_BIT];
    assign first_alarm_enable = control_reg[`AMOS_CTL_A0_EN_BIT];
    assign second_alarm_enable = control_reg[`AMOS_CTL_A1_EN_BIT];
    assign square_wave_rate_select = control_reg[1:0];
    assign alarm_en = {second_alarm_enable, first_alarm_enable};
    assign flag_now = {second_alarm_match_flag, first_alarm_match_flag};

    ////////////////////////////////////////////////////////////////////////
    // address decode helpers

    // alarm unit (0 or 1) that owns an address
    function alarm_of;
        input [7:0] a;
        begin
            if (a >= `AMOS_A1_SEC_OFS) begin
                alarm_of = 1'b1;
            end else begin
                alarm_of = 1'b0;
            end
        end
    endfunction

    // field within an alarm set: 0 sec .. 5 month, 7 not an alarm register
    function [2:0] field_of;
        input [7:0] a;
        reg [7:0] d;
        begin
            if (a >= `AMOS_A0_SEC_OFS && a <= `AMOS_A0_MONTH_OFS) begin
                d = a - `AMOS_A0_SEC_OFS;
            end else if (a >= `AMOS_A1_SEC_OFS &&
                         a <= `AMOS_A1_MONTH_OFS) begin
                d = a - `AMOS_A1_SEC_OFS;
            end else begin
                d = 8'h07;
            end
            field_of = d[2:0];
        end
    endfunction

    wire wr_alarm;
    wire [2:0] wr_field;

    assign wr_alarm = alarm_of(reg_addr);
    assign wr_field = field_of(reg_addr);

    ////////////////////////////////////////////////////////////////////////
    // match evaluation

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_eval
            amos_match_eval u_eval (
                .match_sel(alarm_match_select_reg[g]),
                .alarm_sec(sec_reg[g]),
                .alarm_min(min_reg[g]),
                .alarm_hour(hour_reg[g]),
                .alarm_wkday(day_of_week_value_reg[g]),
                .alarm_date(date_reg[g]),
                .alarm_month(month_reg[g]),
                .now_sec(now_sec),
                .now_min(now_min),
                .now_hour(now_hour),
                .now_wkday(now_wkday),
                .now_date(now_date),
                .now_month(now_month),
                .match(match[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // match flags

    always @* begin
        for (i = 0; i < 2; i = i + 1) begin
            flag_next[i] = flag_now[i];
            // any weekday write clears, whatever bit 3 holds
            if (reg_we && wr_field == 3'h3 && wr_alarm == i[0]) begin
                flag_next[i] = 1'b0;
                // still matching at the clear: set again, set wins
                if (alarm_en[i] && match[i]) begin
                    flag_next[i] = 1'b1;
                end
            end
            if (alarm_en[i] && match[i] && sec_tick) begin
                flag_next[i] = 1'b1;
            end
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            first_alarm_match_flag <= 1'b0;
            second_alarm_match_flag <= 1'b0;
        end else if (ce) begin
            first_alarm_match_flag <= flag_next[0];
            second_alarm_match_flag <= flag_next[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register writes

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (k = 0; k < 2; k = k + 1) begin
                sec_reg[k] <= 7'h00;
                min_reg[k] <= 7'h00;
                hour_reg[k] <= 6'h00;
                day_of_week_value_reg[k] <= `AMOS_WKDAY_RST;
                alarm_match_select_reg[k] <= 3'h0;
                alarm_output_polarity_reg[k] <= 1'b0;
                date_reg[k] <= `AMOS_DATE_RST;
                month_reg[k] <= `AMOS_MONTH_RST;
            end
            control_reg <= `AMOS_CONTROL_RST;
        end else if (ce && reg_we) begin
            if (reg_addr == `AMOS_CONTROL_OFS) begin
                control_reg <= reg_wdata;
            end else if (wr_field == 3'h0) begin
                sec_reg[wr_alarm] <= reg_wdata[6:0];
            end else if (wr_field == 3'h1) begin
                min_reg[wr_alarm] <= reg_wdata[6:0];
            end else if (wr_field == 3'h2) begin
                hour_reg[wr_alarm] <= reg_wdata[5:0];
            end else if (wr_field == 3'h3) begin
                alarm_output_polarity_reg[wr_alarm] <=
                    reg_wdata[`AMOS_WK_POL_BIT];
                alarm_match_select_reg[wr_alarm] <=
                    reg_wdata[`AMOS_WK_SEL_HI:`AMOS_WK_SEL_LO];
                day_of_week_value_reg[wr_alarm] <= reg_wdata[2:0];
            end else if (wr_field == 3'h4) begin
                date_reg[wr_alarm] <= reg_wdata[5:0];
            end else if (wr_field == 3'h5) begin
                month_reg[wr_alarm] <= reg_wdata[4:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register reads, one cycle after the address

    always @* begin
        rdata_next = 8'h00;
        if (reg_addr == `AMOS_CONTROL_OFS) begin
            rdata_next = control_reg;
        end else if (wr_field == 3'h0) begin
            rdata_next = {1'b0, sec_reg[wr_alarm]};
        end else if (wr_field == 3'h1) begin
            rdata_next = {1'b0, min_reg[wr_alarm]};
        end else if (wr_field == 3'h2) begin
            rdata_next = {1'b0, now_format_12h, hour_reg[wr_alarm]};
        end else if (wr_field == 3'h3) begin
            rdata_next = {alarm_output_polarity_reg[wr_alarm],
                          alarm_match_select_reg[wr_alarm],
                          flag_now[wr_alarm],
                          day_of_week_value_reg[wr_alarm]};
        end else if (wr_field == 3'h4) begin
            rdata_next = {2'b00, date_reg[wr_alarm]};
        end else if (wr_field == 3'h5) begin
            rdata_next = {3'b000, month_reg[wr_alarm]};
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (ce) begin
            reg_rdata <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // square wave from the oscillator input

    reg osc_meta_reg;
    reg osc_sync_reg;
    reg osc_prev_reg;
    reg [13:0] div_cnt_reg;
    reg sqw_reg;
    reg [13:0] half_limit;
    wire osc_rise;

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            osc_meta_reg <= 1'b0;
            osc_sync_reg <= 1'b0;
            osc_prev_reg <= 1'b0;
        end else if (ce) begin
            osc_meta_reg <= osc_in;
            osc_sync_reg <= osc_meta_reg;
            osc_prev_reg <= osc_sync_reg;
        end
    end

    assign osc_rise = osc_sync_reg & ~osc_prev_reg;

    always @* begin
        case (square_wave_rate_select)
            2'h0: half_limit = `AMOS_HALF_DIV32768;
            2'h1: half_limit = `AMOS_HALF_DIV8;
            default: half_limit = `AMOS_HALF_DIV4;
        endcase
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            div_cnt_reg <= 14'h0000;
            sqw_reg <= 1'b0;
        end else if (ce) begin
            if (!square_wave_enable) begin
                div_cnt_reg <= 14'h0000;
                sqw_reg <= 1'b0;
            end else if (osc_rise) begin
                if (div_cnt_reg >= half_limit) begin
                    div_cnt_reg <= 14'h0000;
                    sqw_reg <= ~sqw_reg;
                end else begin
                    div_cnt_reg <= div_cnt_reg + 14'h0001;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin mode select and open-drain drive

    reg pin_level;
    reg alarm_level;

    always @* begin
        if (first_alarm_enable && second_alarm_enable) begin
            // dual alarm combining uses the first set's polarity bit
            if (alarm_output_polarity_reg[0]) begin
                alarm_level = first_alarm_match_flag |
                    second_alarm_match_flag;
            end else begin
                alarm_level = ~(first_alarm_match_flag &
                    second_alarm_match_flag);
            end
        end else if (first_alarm_enable) begin
            alarm_level = alarm_output_polarity_reg[0] ?
                first_alarm_match_flag : ~first_alarm_match_flag;
        end else begin
            alarm_level = alarm_output_polarity_reg[1] ?
                second_alarm_match_flag : ~second_alarm_match_flag;
        end
    end

    always @* begin
        if (square_wave_enable) begin
            if (square_wave_rate_select == 2'h3) begin
                pin_level = osc_sync_reg;
            end else begin
                pin_level = sqw_reg;
            end
        end else if (first_alarm_enable || second_alarm_enable) begin
            pin_level = alarm_level;
        end else begin
            pin_level = control_reg[`AMOS_CTL_LEVEL_BIT];
        end
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            multi_function_pin_out <= 1'b0;
            multi_function_pin_oe_n <= 1'b1;
        end else if (ce) begin
            multi_function_pin_out <= 1'b0;
            multi_function_pin_oe_n <= pin_level;
        end
    end

endmodule // amos_top

// ===== verif/amos_host_model.sv
// host side of the pin: pull-up and a count of rising edges seen
`timescale 1ns/1ps
module amos_host_model (
    input wire multi_function_pin_out,
    input wire multi_function_pin_oe_n,
    output wire pin_level,
    output wire [15:0] rise_count
);
    // starts at zero before any process runs, so the first edge counts
    reg [15:0] count_reg = 16'h0000;
    // released line is pulled high, so no stale value is seen
    assign pin_level = multi_function_pin_oe_n ? 1'b1 : multi_function_pin_out;
    assign rise_count = count_reg;
    always @(posedge pin_level) begin
        count_reg <= count_reg + 16'h0001;
    end
endmodule // amos_host_model

// ===== verif/amos_top_bench.sv
// self-checking bench for the alarm match and output select block
`timescale 1ns/1ps
module amos_top_bench;
    reg clk, resetn, ce, reg_we, now_format_12h, sec_tick, osc_in;
    reg [7:0] reg_addr, reg_wdata;
    reg [6:0] now_sec, now_min;
    reg [5:0] now_hour, now_date;
    reg [4:0] now_month;
    reg [2:0] now_wkday, sel;
    wire [7:0] reg_rdata;
    wire pin_out, pin_oe_n, flag0, flag1, pin_level;
    wire [15:0] rise_count;
    reg [15:0] c0;
    integer err_count, compares, i;
    amos_top dut_u (.clk(clk), .resetn(resetn), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_rdata(reg_rdata),
        .now_sec(now_sec), .now_min(now_min), .now_hour(now_hour),
        .now_format_12h(now_format_12h), .now_wkday(now_wkday),
        .now_date(now_date), .now_month(now_month), .sec_tick(sec_tick),
        .osc_in(osc_in), .multi_function_pin_out(pin_out),
        .multi_function_pin_oe_n(pin_oe_n), .first_alarm_match_flag(flag0),
        .second_alarm_match_flag(flag1));
    amos_host_model host_u (.multi_function_pin_out(pin_out),
        .multi_function_pin_oe_n(pin_oe_n), .pin_level(pin_level),
        .rise_count(rise_count));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        osc_in = 1'b0;
        forever #15258.789 osc_in = ~osc_in;
    end
    task chk(input string what, input [7:0] exp, input [7:0] got);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("BAD %s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            reg_addr = a;
            reg_wdata = d;
            reg_we = 1'b1;
            @(posedge clk);
            #2;
            reg_we = 1'b0;
            @(posedge clk);
            #2;
        end
    endtask
    task rd(input [7:0] a, input [7:0] exp, input string what);
        begin
            reg_addr = a;
            repeat (2) @(posedge clk);
            #2;
            chk(what, exp, reg_rdata);
        end
    endtask
    task tick;
        begin
            sec_tick = 1'b1;
            @(posedge clk);
            #2;
            sec_tick = 1'b0;
            repeat (2) @(posedge clk);
            #2;
        end
    endtask
    // time equal to the stored alarm values except field k
    task set_now(input integer k);
        begin
            now_sec = (k == 0) ? 7'h26 : 7'h25;
            now_min = (k == 1) ? 7'h48 : 7'h47;
            now_hour = (k == 2) ? 6'h11 : 6'h31;
            now_wkday = (k == 3) ? 3'h4 : 3'h3;
            now_date = (k == 4) ? 6'h18 : 6'h19;
            now_month = (k == 5) ? 5'h11 : 5'h12;
        end
    endtask
    task wrap_up;
        begin
            $display("compares %0d mismatches %0d", compares, err_count);
            if (err_count == 0 && compares > 0) begin
                $display("ALL TESTS PASSED");
            end else begin
                $display("TESTS FAILED");
            end
            $finish;
        end
    endtask
    initial begin
        repeat (80000) @(posedge clk);
        err_count = err_count + 1;
        wrap_up;
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        err_count = 0;
        compares = 0;
        resetn = 1'b0;
        ce = 1'b1;
        reg_we = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        sec_tick = 1'b0;
        now_format_12h = 1'b0;
        set_now(0);
        repeat (2) @(posedge clk);
        #2;
        resetn = 1'b1;
        rd(8'h07, 8'h80, "control");
        rd(8'h0D, 8'h01, "weekday0");
        rd(8'h14, 8'h01, "weekday1");
        rd(8'h0E, 8'h01, "date0");
        rd(8'h16, 8'h01, "month1");
        rd(8'h09, 8'h00, "unmapped");
        $display("test reset values done");
        now_format_12h = 1'b1;
        wr(8'h0C, 8'hFF);
        rd(8'h0C, 8'h7F, "hour0 12h");
        now_format_12h = 1'b0;
        rd(8'h0C, 8'h3F, "hour0 24h");
        wr(8'h13, 8'h23);
        rd(8'h13, 8'h23, "hour1");
        wr(8'h0E, 8'hFF);
        rd(8'h0E, 8'h3F, "date0");
        wr(8'h16, 8'hFF);
        rd(8'h16, 8'h1F, "month1");
        wr(8'h0D, 8'h0F);
        rd(8'h0D, 8'h07, "weekday0");
        ce = 1'b0;
        wr(8'h0E, 8'h05);
        ce = 1'b1;
        rd(8'h0E, 8'h3F, "frozen date0");
        $display("test field layout done");
        now_format_12h = 1'b1;
        wr(8'h0A, 8'h25);
        wr(8'h0B, 8'h47);
        wr(8'h0C, 8'h31);
        wr(8'h0E, 8'h19);
        wr(8'h0F, 8'h12);
        wr(8'h07, 8'h10);
        for (i = 0; i < 6; i = i + 1) begin
            sel = (i == 5) ? 3'h7 : i[2:0];
            set_now(i);
            // first write may re-set via the old selector; second clears
            repeat (2) wr(8'h0D, {1'b1, sel, 4'h3});
            tick;
            chk("flag0 off", 8'h00, {7'h00, flag0});
            chk("pin off", 8'h00, {7'h00, pin_level});
            set_now(6);
            tick;
            chk("flag0 on", 8'h01, {7'h00, flag0});
            chk("pin on", 8'h01, {7'h00, pin_level});
        end
        wr(8'h0D, 8'hF3);
        rd(8'h0D, 8'hFB, "flag0 again");
        wr(8'h0D, 8'h73);
        rd(8'h0D, 8'h7B, "low polarity");
        chk("pin low", 8'h00, {7'h00, pin_level});
        $display("test alarm match done");
        wr(8'h11, 8'h25);
        wr(8'h12, 8'h47);
        wr(8'h13, 8'h31);
        wr(8'h15, 8'h19);
        wr(8'h16, 8'h12);
        wr(8'h14, 8'h73);
        wr(8'h07, 8'h30);
        chk("dual one", 8'h01, {7'h00, pin_level});
        tick;
        chk("dual both", 8'h00, {7'h00, pin_level});
        chk("flag1 on", 8'h01, {7'h00, flag1});
        set_now(5);
        wr(8'h0D, 8'hF3);
        chk("flag0 cleared", 8'h00, {7'h00, flag0});
        chk("dual or", 8'h01, {7'h00, pin_level});
        wr(8'h07, 8'h00);
        chk("gp low", 8'h00, {7'h00, pin_level});
        wr(8'h07, 8'h80);
        chk("gp high", 8'h01, {7'h00, pin_level});
        $display("test pin modes done");
        for (i = 0; i < 3; i = i + 1) begin
            wr({6'h3C, 2'h3 - i[1:0]}, 8'h00);
            wr(8'h07, {6'h3C, 2'h3 - i[1:0]});
            repeat (2) @(posedge osc_in);
            c0 = rise_count;
            repeat (8) @(posedge osc_in);
            chk("rises", (i == 0) ? 8'h08 : (i == 1) ? 8'h02 : 8'h01,
                rise_count[7:0] - c0[7:0]);
            @(posedge clk);
            #2;
        end
        $display("test square wave done");
        wrap_up;
    end
endmodule // amos_top_bench

// ===== verif/amos_top_sva.sv
// assertion checker for the alarm match and output select block
`timescale 1ns/1ps
module amos_top_chk (
    input wire clk,
    input wire resetn,
    input wire ce,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_we,
    input wire [7:0] reg_rdata,
    input wire now_format_12h,
    input wire sec_tick,
    input wire multi_function_pin_out,
    input wire multi_function_pin_oe_n,
    input wire first_alarm_match_flag,
    input wire second_alarm_match_flag
);
    reg [7:0] ctl_reg;
    reg pol0_reg;
    wire wr0 = ce && reg_we && reg_addr == 8'h0D;
    wire wr1 = ce && reg_we && reg_addr == 8'h14;
    // shadow of control and the first polarity bit, as written
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctl_reg <= 8'h80;
            pol0_reg <= 1'b0;
        end else begin
            if (ce && reg_we && reg_addr == 8'h07) ctl_reg <= reg_wdata;
            if (wr0) pol0_reg <= reg_wdata[7];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////
    a_pin_open_drain:
        assert property (multi_function_pin_out == 1'b0)
        else $error("pin data line driven high");
    a_flag_stays_set:
        assert property (first_alarm_match_flag && !wr0 |=> first_alarm_match_flag)
        else $error("first flag dropped without a write");
    a_flag_has_cause:
        assert property ($rose(second_alarm_match_flag) |-> $past(sec_tick) || $past(wr1))
        else $error("second flag rose without a tick");
    a_write_clears_flag:
        assert property (wr0 && !sec_tick && !ctl_reg[4] |=> !first_alarm_match_flag)
        else $error("weekday write left flag set");
    a_gp_level:
        assert property (ce && ctl_reg[6:4] == 3'b000
            |=> multi_function_pin_oe_n == $past(ctl_reg[7]))
        else $error("general purpose level wrong");
    a_single_follows:
        assert property (ce && ctl_reg[6:4] == 3'b001 |=> multi_function_pin_oe_n
            == ($past(pol0_reg) ~^ $past(first_alarm_match_flag)))
        else $error("single alarm pin wrong");
    a_dual_combine:
        assert property (ce && ctl_reg[6:4] == 3'b011 |=> multi_function_pin_oe_n
            == ($past(pol0_reg) ? ($past(first_alarm_match_flag)
            || $past(second_alarm_match_flag)) : !($past(first_alarm_match_flag)
            && $past(second_alarm_match_flag))))
        else $error("dual alarm pin wrong");
    a_hour_format:
        assert property (ce && (reg_addr == 8'h0C || reg_addr == 8'h13)
            |=> reg_rdata[7:6] == {1'b0, $past(now_format_12h)})
        else $error("hour format bit wrong");
    a_date_upper:
        assert property (ce && (reg_addr == 8'h0E || reg_addr == 8'h15)
            |=> reg_rdata[7:6] == 2'b00)
        else $error("date upper bits set");
    cover property ($rose(first_alarm_match_flag));
    cover property (ctl_reg[6:4] == 3'b011 && second_alarm_match_flag);
    cover property (ctl_reg[6] && $rose(multi_function_pin_oe_n));
endmodule // amos_top_chk

bind amos_top amos_top_chk chk_u (.clk(clk), .resetn(resetn), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_rdata(reg_rdata), .now_format_12h(now_format_12h),
    .sec_tick(sec_tick), .multi_function_pin_out(multi_function_pin_out),
    .multi_function_pin_oe_n(multi_function_pin_oe_n),
    .first_alarm_match_flag(first_alarm_match_flag),
    .second_alarm_match_flag(second_alarm_match_flag));
